// ===== src/rng_health_defs.vh
`ifndef RNG_HEALTH_DEFS_VH
`define RNG_HEALTH_DEFS_VH
// ==========================================
// word formats
`define WORD_W          16
`define FIFO_DEPTH      8
`define FIFO_AW         3
// ==========================================
// total failure: length of the run of equal raw bits that fails
`define STUCK_LIMIT     8'h20
// ==========================================
// online test window and tolerance on ones count
`define WIN_LEN         9'h100
`define ONES_LO         9'h060
`define ONES_HI         9'h0A0
// ==========================================
// pair balance: transitions per window must stay in range
`define TRANS_LO        9'h050
`define TRANS_HI        9'h0B0
// ==========================================
// start-up: windows that must pass before output opens
`define STARTUP_WINS    2'h2
`endif

// ===== src/rng_word_fifo.v
`timescale 1ns/1ps
// ==========================================
// synchronous word fifo, flip-flop storage
module rng_word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // fill side
  input  wire             i_flush,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // handshakes
  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  // pointers and occupancy, flush drops everything
  always @(posedge i_clk) begin
    if (!i_rst_n || i_flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // storage
  always @(posedge i_clk) begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule // rng_word_fifo

// ===== src/physical_rng_health_gating.v
// Summary of operation
// - total failure test runs from start-up
// - no words after total failure
// - drop words holding post-failure raw bits
// - online statistical test at start and always
// - no output before start-up pass or after defect
// - online test runs continuously, bounded window
// - words of 8 or 16 bits selectable
// - entropy above 0.997 per bit, source quality
// - words pass test procedure A
// - repeated consecutive block counts as failure
`timescale 1ns/1ps
`include "rng_health_defs.vh"
module physical_rng_health_gating (
  // clock and reset
  input  wire                i_clk,
  input  wire                i_rst_n,
  // raw entropy source
  input  wire                i_raw_bit,
  input  wire                i_raw_valid,
  // configuration
  input  wire                i_word16,
  // consumer side
  input  wire                i_word_ready,
  output wire                o_word_valid,
  output wire [`WORD_W-1:0]  o_word,
  // status
  output wire                o_ready,
  output reg                 o_fail,
  output reg                 o_total_fail,
  output reg                 o_online_fail,
  output reg                 o_repeat_fail
);
  localparam ST_STARTUP = 2'b00;
  localparam ST_RUN     = 2'b01;
  localparam ST_FAIL    = 2'b10;

  reg  [1:0]         state;
  reg  [1:0]         next_state;
  reg                last_bit;
  reg  [7:0]         run_len;
  reg  [8:0]         win_cnt;
  reg  [8:0]         ones_cnt;
  reg  [8:0]         trans_cnt;
  reg  [1:0]         wins_ok;
  reg  [`WORD_W-1:0] shreg;
  reg  [4:0]         bit_cnt;
  reg  [`WORD_W-1:0] prev_word;
  reg                prev_ok;
  reg  [`WORD_W-1:0] asm_word;
  reg                asm_valid;
  wire               take;
  wire               stuck;
  wire               win_end;
  wire               win_bad;
  wire [4:0]         word_bits;
  wire               word_done;
  wire [`WORD_W-1:0] new_word;
  wire               repeat_hit;
  wire               any_fail;
  wire               fifo_in_ready;
  wire               fifo_out_valid;

  // ==========================================
  // raw bit health
  assign take    = i_raw_valid;
  // stuck source check
  // run_len holds one less than the equal bits seen, so the incoming bit is the limit-th one here
  assign stuck   = take && (i_raw_bit == last_bit) && (run_len >= `STUCK_LIMIT - 8'h02);
  assign win_end = take && (win_cnt == `WIN_LEN - 9'h001);
  assign win_bad = win_end && ((ones_cnt < `ONES_LO) || (ones_cnt > `ONES_HI) ||
                               (trans_cnt < `TRANS_LO) || (trans_cnt > `TRANS_HI));

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      last_bit  <= 1'b0;
      run_len   <= 8'h00;
      win_cnt   <= 9'h000;
      ones_cnt  <= 9'h000;
      trans_cnt <= 9'h000;
      wins_ok   <= 2'h0;
    end else if (take) begin
      last_bit <= i_raw_bit;
      run_len  <= (i_raw_bit == last_bit) ? run_len + 8'h01 : 8'h00;
      if (win_end) begin
        win_cnt   <= 9'h000;
        ones_cnt  <= 9'h000;
        trans_cnt <= 9'h000;
        if (!win_bad && wins_ok != `STARTUP_WINS)
          wins_ok <= wins_ok + 2'h1;
      end else begin
        win_cnt   <= win_cnt + 9'h001;
        ones_cnt  <= ones_cnt + {8'h00, i_raw_bit};
        trans_cnt <= trans_cnt + {8'h00, (i_raw_bit != last_bit)};
      end
    end
  end

  // ==========================================
  // word assembly, 8 or 16 bits
  // width select
  assign word_bits = i_word16 ? 5'd16 : 5'd8;
  assign word_done = take && (bit_cnt == word_bits - 5'd1);
  assign new_word  = i_word16 ? {shreg[14:0], i_raw_bit} : {8'h00, shreg[6:0], i_raw_bit};
  assign repeat_hit = word_done && prev_ok && (new_word == prev_word);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      shreg     <= {`WORD_W{1'b0}};
      bit_cnt   <= 5'd0;
      prev_word <= {`WORD_W{1'b0}};
      prev_ok   <= 1'b0;
      asm_word  <= {`WORD_W{1'b0}};
      asm_valid <= 1'b0;
    end else begin
      asm_valid <= 1'b0;
      if (take) begin
        shreg   <= {shreg[`WORD_W-2:0], i_raw_bit};
        bit_cnt <= word_done ? 5'd0 : bit_cnt + 5'd1;
      end
      if (word_done) begin
        prev_word <= new_word;
        prev_ok   <= 1'b1;
        asm_word  <= new_word;
        asm_valid <= (state == ST_RUN) && !stuck && !win_bad && !repeat_hit;
      end
    end
  end

  // ==========================================
  // health state
  assign any_fail = stuck || win_bad || repeat_hit;

  always @* begin
    next_state = state;
    case (state)
      ST_STARTUP: begin
        if (any_fail)
          next_state = ST_FAIL;
        else if (wins_ok == `STARTUP_WINS)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (any_fail)
          next_state = ST_FAIL;
      end
      ST_FAIL:
        next_state = ST_FAIL;
      default:
        next_state = ST_FAIL;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state         <= ST_STARTUP;
      o_fail        <= 1'b0;
      o_total_fail  <= 1'b0;
      o_online_fail <= 1'b0;
      o_repeat_fail <= 1'b0;
    end else begin
      state <= next_state;
      if (any_fail)
        o_fail <= 1'b1;
      if (stuck)
        o_total_fail <= 1'b1;
      if (win_bad)
        o_online_fail <= 1'b1;
      if (repeat_hit)
        o_repeat_fail <= 1'b1;
    end
  end

  assign o_ready = (state == ST_RUN);

  // ==========================================
  // output buffer, flushed on failure
  // flush pending words
  rng_word_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (any_fail || state == ST_FAIL),
    .i_in_valid  (asm_valid && state == ST_RUN),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (asm_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word)
  );

  assign o_word_valid = fifo_out_valid && (state == ST_RUN) && !any_fail;
endmodule // physical_rng_health_gating

// ===== verif/rng_gate_properties.sv
`timescale 1ns/1ps
`include "rng_health_defs.vh"
// ==========================================
// health gating checker
module rng_gate_chk (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // watched ports
  input wire i_raw_bit,
  input wire i_raw_valid,
  input wire i_word16,
  input wire i_word_ready,
  input wire o_word_valid,
  input wire [15:0] o_word,
  input wire o_ready,
  input wire o_fail,
  input wire o_total_fail,
  input wire o_online_fail,
  input wire o_repeat_fail
);
  reg       last;
  reg [7:0] run;
  // length of the run of equal raw bits
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      run <= 8'h00;
    end else if (i_raw_valid) begin
      run <= (run != 8'h00 && i_raw_bit == last) ? run + 8'h01 : 8'h01;
      last <= i_raw_bit;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // a waiting word vanished without being taken
  sequence s_lost;
    $fell(o_word_valid) && !$past(i_word_ready);
  endsequence
  AST_OPEN: assert property (o_word_valid |-> o_ready)
    else $error("word while closed");
  AST_MUTE: assert property (o_fail |-> !o_word_valid && !o_ready)
    else $error("output after failure");
  AST_STICK: assert property (o_fail |=> o_fail)
    else $error("fail flag cleared");
  AST_SUM: assert property (o_total_fail || o_online_fail || o_repeat_fail |-> ##[0:1] o_fail)
    else $error("fail flag missing");
  AST_STUCK: assert property (run == `STUCK_LIMIT |-> ##[0:2] o_total_fail)
    else $error("stuck run missed");
  AST_HOLD: assert property (s_lost |-> ##[0:1] o_fail)
    else $error("word lost");
  AST_ZEXT: assert property (o_word_valid && !i_word16 |-> o_word[15:8] == 8'h00)
    else $error("byte not zero extended");
  AST_RISE: assert property ($rose(o_ready) |-> !o_fail)
    else $error("opened with failure");
endmodule // rng_gate_chk
bind physical_rng_health_gating rng_gate_chk u_chk (.i_clk, .i_rst_n, .i_raw_bit, .i_raw_valid,
  .i_word16, .i_word_ready, .o_word_valid, .o_word, .o_ready, .o_fail, .o_total_fail,
  .o_online_fail, .o_repeat_fail);

// ===== verif/tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the gated rng stage
module tb;
  reg i_clk, i_rst_n, i_raw_bit, i_raw_valid, i_word16, i_word_ready;
  wire o_word_valid, o_ready, o_fail, o_total_fail, o_online_fail, o_repeat_fail;
  wire [15:0] o_word;
  integer n_mismatch, n_checks, cyc, nb;
  reg [7:0] lf;
  reg [15:0] acc, w;
  reg [15:0] q[$];
  physical_rng_health_gating dut (.i_clk, .i_rst_n, .i_raw_bit, .i_raw_valid, .i_word16,
    .i_word_ready, .o_word_valid, .o_word, .o_ready, .o_fail, .o_total_fail,
    .o_online_fail, .o_repeat_fail);
  // clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_checks = n_checks + 1;
    if (e !== g) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one raw bit, first bit is the msb of the expected word
  task send(input b);
    i_raw_bit <= b;
    i_raw_valid <= 1'b1;
    acc = {acc[14:0], b};
    nb = nb + 1;
    if (nb == (i_word16 ? 16 : 8)) begin
      q.push_back(i_word16 ? acc : {8'h00, acc[7:0]});
      nb = 0;
    end
    @(posedge i_clk);
  endtask
  // lfsr bits, bias forces every other bit high
  task send_lf(input integer n, input bias);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      send(lf[7] | (bias & i[0]));
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    end
  endtask
  task idle(input integer n, input rdy);
    i_raw_valid <= 1'b0;
    i_word_ready <= rdy;
    repeat (n) @(posedge i_clk);
    i_word_ready <= 1'b0;
  endtask
  task pop;
    integer j;
    for (j = 0; j < 20 && o_word_valid !== 1'b1; j = j + 1) @(posedge i_clk);
    chk("word", q.pop_front(), o_word);
    i_word_ready <= 1'b1;
    @(posedge i_clk);
    i_word_ready <= 1'b0;
    @(posedge i_clk);
  endtask
  // reset, then two test windows before output opens
  task startup(input bias);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    nb = 0;
    @(posedge i_clk);
    send_lf(511, bias);
    idle(3, 1'b0);
    chk("early", 16'h0000, {o_ready, o_word_valid});
    send_lf(1, bias);
    idle(20, 1'b1);
    chk("open", {bias, !bias}, {o_online_fail, o_ready});
    q.delete();
  endtask
  // ten words into eight places, then bytes
  task t_fill;
    send_lf(160, 1'b0);
    idle(4, 1'b0);
    repeat (8) pop;
    chk("drop", 16'h0000, o_word_valid);
    q.delete();
    i_word16 <= 1'b0;
    idle(1, 1'b0);
    send_lf(24, 1'b0);
    idle(4, 1'b0);
    repeat (3) pop;
    i_word16 <= 1'b1;
    idle(1, 1'b0);
  endtask
  // same word twice, first one still waiting
  task t_repeat;
    w = 16'hA5C3;
    repeat (32) begin
      send(w[15]);
      w = {w[14:0], w[15]};
    end
    idle(5, 1'b0);
    chk("repeat", 16'h000C, {o_repeat_fail, o_fail, o_ready, o_word_valid});
  endtask
  // source stuck at zero with words waiting
  task t_stuck;
    send_lf(32, 1'b0);
    repeat (32) send(1'b0);
    idle(5, 1'b0);
    chk("stuck", 16'h000C, {o_total_fail, o_fail, o_ready, o_word_valid});
  endtask
  // main sequence
  initial begin
    {i_rst_n, i_raw_bit, i_raw_valid, i_word_ready} = 4'h0;
    i_word16 = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    nb = 0;
    lf = 8'h5A;
    acc = 16'h0000;
    @(posedge i_clk);
    startup(1'b0);
    t_fill;
    t_repeat;
    startup(1'b0);
    t_stuck;
    startup(1'b1);
    end_of_test;
  end
endmodule // tb
